// [flash_ctrl_defines.svh]
// Offsets, field positions, reset values and range bounds for the flash control bank.
// Assumes inclusion by bare name from the checker, the bank module and the bench.
`ifndef FLASH_CTRL_DEFINES_SVH
`define FLASH_CTRL_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_MODE_CONTROL    8'h00
`define OFS_ERROR_STATUS    8'h01
`define OFS_ERASE_BLOCK     8'h02
`define OFS_POWER_CONTROL   8'h03
`define OFS_REG_ENABLE      8'h04

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_SW_WRITE_ENABLE 6
`define BIT_ERROR_FLAG      7
`define BIT_POWERDOWN_DIS   7
`define BIT_ACCESS_ENABLE   7
`define EBS_MSB             6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BYTE            8'h00
`define RST_EBS             7'h00

// ----------------------------------------
// Erase block bounds
// ----------------------------------------
`define BLK_1K_SIZE         16'h0400
`define BLK_1K_LAST_OFS     16'h03ff
`define BLK_28K_BASE        16'h1000
`define BLK_28K_LAST        16'h7fff
`define BLK_16K_BASE        16'h8000
`define BLK_16K_LAST        16'hbfff
`define BLK_4K_BASE         16'hc000
`define BLK_4K_LAST         16'hcfff

`endif

// [flash_ctrl_pkg.sv]
// Types shared by the flash control bank and its mode capture.
// Assumes compilation before every design module.
package flash_ctrl_pkg;

    // ----------------------------------------
    // Operating mode picked at reset end
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_USER       = 2'b00,
        MODE_BOOT       = 2'b01,
        MODE_PROGRAMMER = 2'b10,
        MODE_UNDEFINED  = 2'b11
    } op_mode_t;

    // ----------------------------------------
    // Boot sequence
    // ----------------------------------------
    typedef enum logic [1:0] {
        BOOT_IDLE  = 2'b00,
        BOOT_LOAD  = 2'b01,
        BOOT_ERASE = 2'b10,
        BOOT_EXEC  = 2'b11
    } boot_state_t;

    // ----------------------------------------
    // Mode strap pins
    // ----------------------------------------
    typedef struct packed {
        logic test_pin;
        logic nmi;
        logic port3_pin6;
        logic portb_pin0;
        logic portb_pin1;
        logic portb_pin2;
    } mode_pins_t;

    // ----------------------------------------
    // Selected erase range
    // ----------------------------------------
    typedef struct packed {
        logic        valid;
        logic [15:0] base;
        logic [15:0] last;
    } erase_range_t;

endpackage

// [flash_ctrl_sva.sv]
// Concurrent checks for the flash control register bank.
// Assumes binding to the bank's top module ports, one clock domain.
`include "flash_ctrl_defines.svh"

module flash_ctrl_sva (
    input wire logic                       clk_in,             // Clock
    input wire logic                       rst_in,             // Reset
    input wire logic [7:0]                 addr_in,            // Offset
    input wire logic [7:0]                 wdata_in,           // Write data
    input wire logic                       wr_in,              // Write strobe
    input wire logic                       rd_in,              // Read strobe
    input wire logic                       flash_error_in,     // Error level
    input wire logic                       subactive_in,       // Subactive
    input wire flash_ctrl_pkg::mode_pins_t mode_pins_in,       // Straps
    input wire logic                       boot_load_done_in,  // Load done
    input wire logic                       erase_done_in,      // Erase done
    input wire logic [7:0]                 rdata_out,          // Read data
    input wire logic [6:0]                 erase_sel_out,      // Select bits
    input wire flash_ctrl_pkg::erase_range_t erase_range_out,  // Range
    input wire logic                       sw_write_en_out,    // Write enable
    input wire logic                       powerdown_out,      // Power-down
    input wire flash_ctrl_pkg::op_mode_t   mode_out,           // Mode
    input wire logic                       boot_serial_en_out, // Serial on
    input wire logic                       erase_all_out,      // Erase all
    input wire logic                       exec_program_out    // Run program
);
    logic acc_ff;
    logic nxt_acc;

    // ----------------------------------------
    // Shadow of the access enable bit
    // ----------------------------------------
    always_comb begin
        nxt_acc = acc_ff;
        if (wr_in && addr_in == `OFS_REG_ENABLE)
            nxt_acc = wdata_in[`BIT_ACCESS_ENABLE];
    end

    always_ff @(posedge clk_in) begin
        if (rst_in)
            acc_ff <= 1'h0;
        else
            acc_ff <= nxt_acc;
    end

    function automatic flash_ctrl_pkg::op_mode_t pick(flash_ctrl_pkg::mode_pins_t p);
        if (!p.test_pin && p.nmi)
            return flash_ctrl_pkg::MODE_USER;
        if (!p.test_pin && p.port3_pin6)
            return flash_ctrl_pkg::MODE_BOOT;
        if (p.test_pin && {p.portb_pin0, p.portb_pin1, p.portb_pin2} == 3'h0)
            return flash_ctrl_pkg::MODE_PROGRAMMER;
        return flash_ctrl_pkg::MODE_UNDEFINED;
    endfunction

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_sel_no_swe: assert property (!sw_write_en_out |=> erase_sel_out == 7'h00)
        else $error("sel with swe low");
    chk_sel_onehot: assert property ($onehot0(erase_sel_out))
        else $error("sel not onehot");
    chk_range_4k: assert property (erase_sel_out == 7'h40 |->
        erase_range_out == {1'h1, `BLK_4K_BASE, `BLK_4K_LAST})
        else $error("4k range");
    chk_range_16k: assert property (erase_sel_out == 7'h20 |->
        erase_range_out == {1'h1, `BLK_16K_BASE, `BLK_16K_LAST})
        else $error("16k range");
    chk_range_28k: assert property (erase_sel_out == 7'h10 |->
        erase_range_out == {1'h1, `BLK_28K_BASE, `BLK_28K_LAST})
        else $error("28k range");
    chk_range_1k: assert property (erase_sel_out inside {7'h01, 7'h02, 7'h04, 7'h08} |->
        erase_range_out.valid && erase_range_out.base[15:12] == 4'h0
        && erase_range_out.base[9:0] == 10'h000 && erase_sel_out[erase_range_out.base[11:10]]
        && erase_range_out.last == erase_range_out.base + 16'h03ff)
        else $error("1k range");
    chk_pd_idle: assert property (!$past(subactive_in) |-> !powerdown_out)
        else $error("pd outside subactive");
    chk_gate_read: assert property (rd_in && addr_in <= 8'h03 && !acc_ff |=> rdata_out == 8'h00)
        else $error("gated read nonzero");
    chk_resv_read: assert property (rd_in && addr_in inside {8'h03, 8'h04} |=>
        rdata_out[6:0] == 7'h00)
        else $error("reserved bits set");
    chk_sel_read: assert property (rd_in && addr_in == 8'h02 && acc_ff && sw_write_en_out |=>
        rdata_out == {1'h0, $past(erase_sel_out)})
        else $error("sel read mismatch");
    chk_mode_pick: assert property ($fell(rst_in) |=> mode_out == pick($past(mode_pins_in)))
        else $error("mode pick");
    chk_boot_serial: assert property ($fell(rst_in) ##1 mode_out == flash_ctrl_pkg::MODE_BOOT
        |=> boot_serial_en_out)
        else $error("boot serial off");
    chk_boot_erase: assert property (boot_serial_en_out && boot_load_done_in |=>
        erase_all_out && !boot_serial_en_out)
        else $error("erase not started");
    chk_boot_exec: assert property (erase_all_out && erase_done_in |=>
        exec_program_out && !erase_all_out)
        else $error("exec not started");

    cov_sel_top: cover property (erase_sel_out == 7'h40);
    cov_powerdown: cover property (powerdown_out);
    cov_exec: cover property (exec_program_out);
endmodule

bind flash_erase_block_power_and_mode_ctrl flash_ctrl_sva flash_ctrl_sva_i (.*);

// [flash_erase_block_power_and_mode_ctrl.sv]
// Flash control register bank: erase block select, power-down control,
// register access gate, reset-end mode pick and the boot sequence steps.
// Assumes a one-cycle strobe register port and pins synchronous to clk_in.
//
// Notes on behaviour
// - The erase block select register is held at zero from the cycle after write enable goes to 0.
// - A write leaving more than one select bit set clears the whole register.
// - Bit 7 of the erase block select register reads 0 and ignores writes.
// - Select bit 6 picks the 4 KB block from c000 to cfff.
// - Select bit 5 picks the 16 KB block from 8000 to bfff.
// - Select bit 4 picks the 28 KB block from 1000 to 7fff.
// - Select bits 0 to 3 each pick a 1 KB block at n times 400 within 0000 to 0fff.
// - With power-down disable 0 the flash powers down in subactive mode, else stays on.
// - Bits 6 to 0 of the power control and register enable registers read 0.
// - The registers at offsets 00 to 03 are reachable only while the access enable bit is 1.
// - Mode is picked from test, nmi, port 3 pin 6 and port B pins 0 to 2 at reset end.
// - Boot mode loads a program over the boot serial channel, erases all flash, runs it.
// - While write enable is 0 no erase block select bit can be set.
//
// The register offsets and the plain strobed port were decided locally.
`include "flash_ctrl_defines.svh"

module flash_erase_block_power_and_mode_ctrl (
    input  wire logic                       clk_in,           // System clock
    input  wire logic                       rst_in,           // Synchronous reset, high
    input  wire logic [7:0]                 addr_in,          // Register offset
    input  wire logic [7:0]                 wdata_in,         // Write data
    input  wire logic                       wr_in,            // Write strobe
    input  wire logic                       rd_in,            // Read strobe
    input  wire logic                       flash_error_in,   // Program/erase error level
    input  wire logic                       subactive_in,     // Chip in subactive mode
    input  wire flash_ctrl_pkg::mode_pins_t mode_pins_in,     // Strap pins
    input  wire logic                       boot_load_done_in,// Program fully received
    input  wire logic                       erase_done_in,    // Whole-flash erase finished
    output logic [7:0]                      rdata_out,        // Read data, one cycle later
    output logic [6:0]                      erase_sel_out,    // Erase block select bits
    output flash_ctrl_pkg::erase_range_t    erase_range_out,  // Selected erase range
    output logic                            sw_write_en_out,  // Write enable level
    output logic                            powerdown_out,    // Flash power-down request
    output flash_ctrl_pkg::op_mode_t        mode_out,         // Mode after reset end
    output logic                            boot_serial_en_out,// Boot serial channel on
    output logic                            erase_all_out,    // Whole-flash erase request
    output logic                            exec_program_out  // Branch to loaded program
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic                         swe_ff;
    logic                         nxt_swe;
    logic [6:0]                   ebs_ff;
    logic [6:0]                   nxt_ebs;
    logic                         pdd_ff;
    logic                         nxt_pdd;
    logic                         acc_en_ff;
    logic                         nxt_acc_en;
    logic [7:0]                   rdata_ff;
    logic [7:0]                   nxt_rdata;
    flash_ctrl_pkg::erase_range_t range_ff;
    flash_ctrl_pkg::erase_range_t nxt_range;
    logic                         pwdn_ff;
    logic                         nxt_pwdn;
    flash_ctrl_pkg::boot_state_t  boot_ff;
    flash_ctrl_pkg::boot_state_t  nxt_boot;
    logic                         serial_en_ff;
    logic                         nxt_serial_en;
    logic                         erase_all_ff;
    logic                         nxt_erase_all;
    logic                         exec_ff;
    logic                         nxt_exec;
    flash_ctrl_pkg::op_mode_t     strap_mode;
    logic                         strap_done;
    logic                         strap_done_q_ff;
    logic                         nxt_strap_done_q;
    logic                         gated_hit;
    logic                         wr_ok;
    logic                         rd_ok;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    function automatic logic more_than_one(input logic [6:0] v);
        more_than_one = |(v & (v - 7'h01));
    endfunction

    function automatic logic is_gated(input logic [7:0] a);
        is_gated = (a == `OFS_MODE_CONTROL) || (a == `OFS_ERROR_STATUS) ||
                   (a == `OFS_ERASE_BLOCK)  || (a == `OFS_POWER_CONTROL);
    endfunction

    function automatic flash_ctrl_pkg::erase_range_t block_range(input logic [6:0] sel);
        flash_ctrl_pkg::erase_range_t r;
        r = '0;
        r.valid = |sel;
        if (sel[6]) begin
            r.base = `BLK_4K_BASE;
            r.last = `BLK_4K_LAST;
        end else if (sel[5]) begin
            r.base = `BLK_16K_BASE;
            r.last = `BLK_16K_LAST;
        end else if (sel[4]) begin
            r.base = `BLK_28K_BASE;
            r.last = `BLK_28K_LAST;
        end else begin
            for (int n = 0; n < 4; n++) begin
                if (sel[n]) begin
                    r.base = 16'(n) * `BLK_1K_SIZE;
                    r.last = r.base + `BLK_1K_LAST_OFS;
                end
            end
        end
        block_range = r;
    endfunction

    // ----------------------------------------
    // Access gate
    // ----------------------------------------
    always_comb begin
        gated_hit = is_gated(addr_in);
        wr_ok     = wr_in && (!gated_hit || acc_en_ff);
        rd_ok     = rd_in && (!gated_hit || acc_en_ff);
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_comb begin
        nxt_swe    = swe_ff;
        nxt_ebs    = ebs_ff;
        nxt_pdd    = pdd_ff;
        nxt_acc_en = acc_en_ff;
        if (wr_ok) begin
            case (addr_in)
                `OFS_MODE_CONTROL: begin
                    nxt_swe = wdata_in[`BIT_SW_WRITE_ENABLE];
                end
                `OFS_ERASE_BLOCK: begin
                    if (swe_ff) begin
                        nxt_ebs = wdata_in[`EBS_MSB:0];
                        if (more_than_one(nxt_ebs)) begin
                            nxt_ebs = `RST_EBS;
                        end
                    end
                end
                `OFS_POWER_CONTROL: begin
                    nxt_pdd = wdata_in[`BIT_POWERDOWN_DIS];
                end
                `OFS_REG_ENABLE: begin
                    nxt_acc_en = wdata_in[`BIT_ACCESS_ENABLE];
                end
                default: begin
                    nxt_swe = swe_ff;
                end
            endcase
        end
        if (!swe_ff) begin
            nxt_ebs = `RST_EBS;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            swe_ff    <= 1'b0;
            ebs_ff    <= `RST_EBS;
            pdd_ff    <= 1'b0;
            acc_en_ff <= 1'b0;
        end else begin
            swe_ff    <= nxt_swe;
            ebs_ff    <= nxt_ebs;
            pdd_ff    <= nxt_pdd;
            acc_en_ff <= nxt_acc_en;
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    always_comb begin
        nxt_rdata = `RST_BYTE;
        if (rd_ok) begin
            case (addr_in)
                `OFS_MODE_CONTROL: begin
                    nxt_rdata[`BIT_SW_WRITE_ENABLE] = swe_ff;
                end
                `OFS_ERROR_STATUS: begin
                    nxt_rdata[`BIT_ERROR_FLAG] = flash_error_in;
                end
                `OFS_ERASE_BLOCK: begin
                    nxt_rdata = {1'b0, ebs_ff};
                end
                `OFS_POWER_CONTROL: begin
                    nxt_rdata[`BIT_POWERDOWN_DIS] = pdd_ff;
                end
                `OFS_REG_ENABLE: begin
                    nxt_rdata[`BIT_ACCESS_ENABLE] = acc_en_ff;
                end
                default: begin
                    nxt_rdata = `RST_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_ff <= `RST_BYTE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ----------------------------------------
    // Erase range and power-down
    // ----------------------------------------
    always_comb begin
        nxt_range = block_range(nxt_ebs);
        nxt_pwdn  = subactive_in && !nxt_pdd;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            range_ff <= '0;
            pwdn_ff  <= 1'b0;
        end else begin
            range_ff <= nxt_range;
            pwdn_ff  <= nxt_pwdn;
        end
    end

    // ----------------------------------------
    // Mode capture at reset end
    // ----------------------------------------
    mode_strap_capture u_strap (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .pins_in  (mode_pins_in),
        .mode_out (strap_mode),
        .done_out (strap_done)
    );

    // ----------------------------------------
    // Boot sequence
    // ----------------------------------------
    always_comb begin
        nxt_boot         = boot_ff;
        nxt_strap_done_q = strap_done;
        case (boot_ff)
            flash_ctrl_pkg::BOOT_IDLE: begin
                if (strap_done && !strap_done_q_ff &&
                    strap_mode == flash_ctrl_pkg::MODE_BOOT) begin
                    nxt_boot = flash_ctrl_pkg::BOOT_LOAD;
                end
            end
            flash_ctrl_pkg::BOOT_LOAD: begin
                if (boot_load_done_in) begin
                    nxt_boot = flash_ctrl_pkg::BOOT_ERASE;
                end
            end
            flash_ctrl_pkg::BOOT_ERASE: begin
                if (erase_done_in) begin
                    nxt_boot = flash_ctrl_pkg::BOOT_EXEC;
                end
            end
            flash_ctrl_pkg::BOOT_EXEC: begin
                nxt_boot = flash_ctrl_pkg::BOOT_EXEC;
            end
            default: begin
                nxt_boot = flash_ctrl_pkg::BOOT_IDLE;
            end
        endcase
        nxt_serial_en = (nxt_boot == flash_ctrl_pkg::BOOT_LOAD);
        nxt_erase_all = (nxt_boot == flash_ctrl_pkg::BOOT_ERASE);
        nxt_exec      = (nxt_boot == flash_ctrl_pkg::BOOT_EXEC);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            boot_ff         <= flash_ctrl_pkg::BOOT_IDLE;
            strap_done_q_ff <= 1'b0;
            serial_en_ff    <= 1'b0;
            erase_all_ff    <= 1'b0;
            exec_ff         <= 1'b0;
        end else begin
            boot_ff         <= nxt_boot;
            strap_done_q_ff <= nxt_strap_done_q;
            serial_en_ff    <= nxt_serial_en;
            erase_all_ff    <= nxt_erase_all;
            exec_ff         <= nxt_exec;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdata_out          = rdata_ff;
    assign erase_sel_out      = ebs_ff;
    assign erase_range_out    = range_ff;
    assign sw_write_en_out    = swe_ff;
    assign powerdown_out      = pwdn_ff;
    assign mode_out           = strap_mode;
    assign boot_serial_en_out = serial_en_ff;
    assign erase_all_out      = erase_all_ff;
    assign exec_program_out   = exec_ff;

endmodule

// [mode_strap_capture.sv]
// Catches the mode strap pins once, in the first cycle after reset release.
// Assumes pins are synchronous to clk_in and settled before release.
module mode_strap_capture (
    input  wire logic                     clk_in,    // System clock
    input  wire logic                     rst_in,    // Synchronous reset, high
    input  wire flash_ctrl_pkg::mode_pins_t pins_in, // Strap pin levels
    output flash_ctrl_pkg::op_mode_t      mode_out,  // Captured mode
    output logic                          done_out   // Capture happened
);

    flash_ctrl_pkg::op_mode_t mode_ff;
    flash_ctrl_pkg::op_mode_t nxt_mode;
    logic                     done_ff;
    logic                     nxt_done;

    // ----------------------------------------
    // Pin table decode
    // ----------------------------------------
    function automatic flash_ctrl_pkg::op_mode_t decode_mode(
        input flash_ctrl_pkg::mode_pins_t p);
        if (!p.test_pin && p.nmi) begin
            decode_mode = flash_ctrl_pkg::MODE_USER;
        end else if (!p.test_pin && !p.nmi && p.port3_pin6) begin
            decode_mode = flash_ctrl_pkg::MODE_BOOT;
        end else if (p.test_pin && !p.portb_pin0 && !p.portb_pin1 && !p.portb_pin2) begin
            decode_mode = flash_ctrl_pkg::MODE_PROGRAMMER;
        end else begin
            decode_mode = flash_ctrl_pkg::MODE_UNDEFINED;
        end
    endfunction

    always_comb begin
        nxt_mode = mode_ff;
        nxt_done = done_ff;
        if (!done_ff) begin
            nxt_mode = decode_mode(pins_in);
            nxt_done = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode_ff <= flash_ctrl_pkg::MODE_USER;
            done_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            done_ff <= nxt_done;
        end
    end

    assign mode_out = mode_ff;
    assign done_out = done_ff;

endmodule

// [test_flash_erase_block_power_and_mode_ctrl.sv]
// Self-checking bench for the flash control register bank.
// Assumes the package, the bank and its checker are compiled before it.
`include "flash_ctrl_defines.svh"

module test_flash_erase_block_power_and_mode_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    logic                           clk_in = 1'h0;
    logic                           rst_in = 1'h1;
    logic [7:0]                     addr_in = 8'h00;
    logic [7:0]                     wdata_in = 8'h00;
    logic                           wr_in = 1'h0;
    logic                           rd_in = 1'h0;
    logic                           flash_error_in = 1'h0;
    logic                           subactive_in = 1'h0;
    flash_ctrl_pkg::mode_pins_t     mode_pins_in = 6'h10;
    logic                           boot_load_done_in = 1'h0;
    logic                           erase_done_in = 1'h0;
    logic [7:0]                     rdata_out;
    logic [6:0]                     erase_sel_out;
    flash_ctrl_pkg::erase_range_t   erase_range_out;
    logic                           sw_write_en_out;
    logic                           powerdown_out;
    flash_ctrl_pkg::op_mode_t       mode_out;
    logic                           boot_serial_en_out;
    logic                           erase_all_out;
    logic                           exec_program_out;
    int                             fail_count = 0;
    int                             compares = 0;
    flash_ctrl_pkg::mode_pins_t     pin_tab [0:5] = '{6'h1f, 6'h08, 6'h20, 6'h30, 6'h24, 6'h00};
    logic [1:0]                     mode_tab [0:5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    logic [31:0]                    rng [0:6] = '{32'h0000_03ff, 32'h0400_07ff, 32'h0800_0bff,
        32'h0c00_0fff, 32'h1000_7fff, 32'h8000_bfff, 32'hc000_cfff};

    always #5 clk_in = ~clk_in;

    flash_erase_block_power_and_mode_ctrl flash_erase_block_power_and_mode_ctrl_i (.*);

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [32:0] exp, input logic [32:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1'h1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'h0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        rd_in <= 1'h1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'h0;
        #1;
        check("read data", {25'h0, exp}, {25'h0, rdata_out});
    endtask

    task automatic do_reset(input flash_ctrl_pkg::mode_pins_t p, input logic [1:0] m);
        @(posedge clk_in);
        rst_in <= 1'h1;
        mode_pins_in <= p;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'h0;
        repeat (2) @(posedge clk_in);
        #1;
        check("mode", {31'h0, m}, {31'h0, mode_out});
    endtask

    task automatic pulse_done(input logic ld, input logic ed, input logic [2:0] exp);
        @(posedge clk_in);
        boot_load_done_in <= ld;
        erase_done_in <= ed;
        @(posedge clk_in);
        boot_load_done_in <= 1'h0;
        erase_done_in <= 1'h0;
        #1;
        check("boot steps", {30'h0, exp},
              {30'h0, boot_serial_en_out, erase_all_out, exec_program_out});
    endtask

    task automatic close_out();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clk_in);
        fail_count++;
        close_out();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 6; i++) begin
            do_reset(pin_tab[i], mode_tab[i]);
            if (i == 1) begin
                pulse_done(1'h0, 1'h1, 3'h4);
                pulse_done(1'h1, 1'h0, 3'h2);
                pulse_done(1'h0, 1'h1, 3'h1);
            end
        end
        do_reset(6'h10, 2'h0);
        flash_error_in <= 1'h1;
        wr(`OFS_POWER_CONTROL, 8'h80);
        for (int a = 0; a < 6; a++)
            rd(a[7:0], 8'h00);
        wr(`OFS_REG_ENABLE, 8'hff);
        rd(`OFS_REG_ENABLE, 8'h80);
        rd(`OFS_ERROR_STATUS, 8'h80);
        rd(`OFS_POWER_CONTROL, 8'h00);
        subactive_in <= 1'h1;
        wr(`OFS_POWER_CONTROL, 8'hff);
        rd(`OFS_POWER_CONTROL, 8'h80);
        check("power-down", 33'h0, {32'h0, powerdown_out});
        wr(`OFS_POWER_CONTROL, 8'h00);
        repeat (2) @(posedge clk_in);
        #1;
        check("power-down", 33'h1, {32'h0, powerdown_out});
        wr(`OFS_ERASE_BLOCK, 8'h01);
        check("erase select", 33'h0, {26'h0, erase_sel_out});
        wr(`OFS_MODE_CONTROL, 8'h40);
        check("write enable", 33'h1, {32'h0, sw_write_en_out});
        for (int i = 0; i < 7; i++) begin
            wr(`OFS_ERASE_BLOCK, 8'h80 | (8'h01 << i));
            check("erase select", {26'h0, 7'h01 << i}, {26'h0, erase_sel_out});
            check("erase range", {1'h1, rng[i]}, erase_range_out);
            rd(`OFS_ERASE_BLOCK, 8'h01 << i);
        end
        wr(`OFS_ERASE_BLOCK, 8'h24);
        check("erase select", 33'h0, {26'h0, erase_sel_out});
        wr(`OFS_ERASE_BLOCK, 8'h20);
        wr(`OFS_MODE_CONTROL, 8'h00);
        repeat (2) @(posedge clk_in);
        #1;
        check("erase select", 33'h0, {26'h0, erase_sel_out});
        wr(`OFS_MODE_CONTROL, 8'h40);
        wr(`OFS_REG_ENABLE, 8'h00);
        wr(`OFS_MODE_CONTROL, 8'h00);
        check("write enable", 33'h1, {32'h0, sw_write_en_out});
        rd(`OFS_MODE_CONTROL, 8'h00);
        wr(`OFS_REG_ENABLE, 8'h80);
        rd(`OFS_MODE_CONTROL, 8'h40);
        close_out();
    end
endmodule
